// ---- nsp_pkg.sv ----
// Purpose: Shared constants for the legacy NMI, speaker and fast reset ports
// Assumes: 8-bit I/O port cycles decoded on a 16-bit I/O address
// Notes: Port addresses, bit positions, reset values and timing counts
package nsp_pkg;
   // ----------------------------------------------------------------
   // Port addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] NSP_ADDR_STATUS_CTRL = 16'h0061;
   localparam logic [15:0] NSP_ADDR_MASK_INDEX = 16'h0070;
   localparam logic [15:0] NSP_ADDR_FAST_RESET = 16'h0092;

   // ----------------------------------------------------------------
   // Status/control port fields
   // ----------------------------------------------------------------
   localparam int NSP_SC_SERR_STAT = 7;
   localparam int NSP_SC_CHK_STAT = 6;
   localparam int NSP_SC_CNT2_OUT = 5;
   localparam int NSP_SC_REFRESH = 4;
   localparam int NSP_SC_CHK_DIS = 3;
   localparam int NSP_SC_SERR_DIS = 2;
   localparam int NSP_SC_SPK_EN = 1;
   localparam int NSP_SC_CNT2_EN = 0;
   localparam logic [7:0] NSP_SC_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Mask/clock index port fields
   // ----------------------------------------------------------------
   localparam int NSP_MI_MASK = 7;
   localparam int NSP_MI_INDEX_W = 7;
   localparam logic NSP_MI_MASK_RESET = 1'b1;
   localparam logic [6:0] NSP_MI_INDEX_RESET = 7'h00;

   // ----------------------------------------------------------------
   // Fast reset / A20 port fields
   // ----------------------------------------------------------------
   localparam int NSP_FR_A20 = 1;
   localparam int NSP_FR_RESET_BIT = 0;
   localparam logic [7:0] NSP_FR_FIXED = 8'h24;
   localparam logic [7:0] NSP_FR_RESET = 8'h24;

   // ----------------------------------------------------------------
   // Timing: reset pulse length in ISA system clock periods
   // ----------------------------------------------------------------
   localparam int NSP_FAST_RST_CYCLES = 4;
   localparam int NSP_CNT_W = 3;

   // Pulse generator states
   typedef enum logic [1:0] {
      NSP_PG_IDLE,
      NSP_PG_PULSE,
      NSP_PG_WAIT_CLEAR
   } nsp_pulse_state_type;
endpackage

// ---- nsp_pulse_gen.sv ----
// Purpose: Fixed-length active-low pulse from a control bit rising edge
// Assumes: Control bit is a register on the same clock
// Notes: Re-arms only once the control bit has been seen low
module nsp_pulse_gen
   import nsp_pkg::*;
#(
   parameter int PULSE_CYCLES = NSP_FAST_RST_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ctrl,
   output logic o_pulse_n
);
   nsp_pulse_state_type state_reg;
   logic [NSP_CNT_W-1:0] count_reg;

   // ----------------------------------------------------------------
   // Pulse sequencer
   // ----------------------------------------------------------------
   // Holding the bit at 1 gives one pulse only; software must clear it first
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= NSP_PG_IDLE;
         count_reg <= '0;
         o_pulse_n <= 1'b1;
      end else begin
         case (state_reg)
            NSP_PG_IDLE: begin
               if (i_ctrl) begin
                  state_reg <= NSP_PG_PULSE;
                  count_reg <= NSP_CNT_W'(PULSE_CYCLES - 1);
                  o_pulse_n <= 1'b0;
               end
            end
            NSP_PG_PULSE: begin
               if (count_reg == '0) begin
                  state_reg <= NSP_PG_WAIT_CLEAR;
                  o_pulse_n <= 1'b1;
               end else begin
                  count_reg <= count_reg - 1'b1;
               end
            end
            NSP_PG_WAIT_CLEAR: begin
               if (!i_ctrl) begin
                  state_reg <= NSP_PG_IDLE;
               end
            end
            default: begin
               state_reg <= NSP_PG_IDLE;
               o_pulse_n <= 1'b1;
            end
         endcase
      end
   end
endmodule // nsp_pulse_gen

// ---- nsp_ports.sv ----
// Purpose: Legacy NMI status/control, NMI mask/clock index and fast reset ports
// Assumes: One I/O cycle strobe per access on the ISA system clock
// Notes: Every access to the mask port, and to the fast reset port while chip-select B enables it, is echoed to ISA
module nsp_ports
   import nsp_pkg::*;
#(
   parameter int PULSE_CYCLES = NSP_FAST_RST_CYCLES
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic i_IO_STB,
   input wire logic i_IO_WR,
   input wire logic [15:0] i_IO_ADDR,
   input wire logic [7:0] i_IO_WDATA,
   input wire logic i_SERR_N,
   input wire logic i_IOCHK_N,
   input wire logic i_CNT2_OUT,
   input wire logic i_REFRESH_DONE,
   input wire logic i_CSB_PORT92_EN,
   output logic [7:0] o_IO_RDATA,
   output logic o_IO_CLAIM,
   output logic o_ISA_FORWARD,
   output logic o_NMI,
   output logic o_CNT2_GATE,
   output logic o_SPEAKER_OUT,
   output logic o_ALTERNATE_A20_GATE,
   output logic o_FAST_CPU_RESET_N,
   output logic [6:0] o_RTC_INDEX
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic serr_meta_reg;
   logic serr_sync_reg;
   logic serr_prev_reg;
   logic chk_meta_reg;
   logic chk_sync_reg;
   logic cnt2_meta_reg;
   logic cnt2_sync_reg;
   logic refr_meta_reg;
   logic refr_sync_reg;
   logic refr_prev_reg;

   // Pins come from other domains; two flops before any logic
   // System error resets to its idle high level, so no false edge after reset
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         serr_meta_reg <= 1'b1;
         serr_sync_reg <= 1'b1;
         serr_prev_reg <= 1'b1;
      end else begin
         serr_meta_reg <= i_SERR_N;
         serr_sync_reg <= serr_meta_reg;
         serr_prev_reg <= serr_sync_reg;
      end
   end

   // Channel check level, idle high
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         chk_meta_reg <= 1'b1;
         chk_sync_reg <= 1'b1;
      end else begin
         chk_meta_reg <= i_IOCHK_N;
         chk_sync_reg <= chk_meta_reg;
      end
   end

   // Counter 2 output level; meaningless until software programs the counter
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         cnt2_meta_reg <= 1'b0;
         cnt2_sync_reg <= 1'b0;
      end else begin
         cnt2_meta_reg <= i_CNT2_OUT;
         cnt2_sync_reg <= cnt2_meta_reg;
      end
   end

   // Refresh done, idle low; third flop gives the rising edge
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         refr_meta_reg <= 1'b0;
         refr_sync_reg <= 1'b0;
         refr_prev_reg <= 1'b0;
      end else begin
         refr_meta_reg <= i_REFRESH_DONE;
         refr_sync_reg <= refr_meta_reg;
         refr_prev_reg <= refr_sync_reg;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic hit_sc;
   logic hit_mi;
   logic hit_fr;
   logic wr_sc;
   logic wr_mi;
   logic wr_fr;
   logic serr_event;
   logic refr_event;

   // Fast reset port is invisible unless chip-select B enables it
   always_comb begin
      hit_sc = 1'b0;
      hit_mi = 1'b0;
      hit_fr = 1'b0;
      if (i_IO_ADDR == NSP_ADDR_STATUS_CTRL) begin
         hit_sc = i_IO_STB;
      end else if (i_IO_ADDR == NSP_ADDR_MASK_INDEX) begin
         hit_mi = i_IO_STB;
      end else if (i_IO_ADDR == NSP_ADDR_FAST_RESET) begin
         hit_fr = i_IO_STB & i_CSB_PORT92_EN;
      end
   end

   assign wr_sc = hit_sc & i_IO_WR;
   assign wr_mi = hit_mi & i_IO_WR;
   assign wr_fr = hit_fr & i_IO_WR;
   // System error is a pulse: catch the falling edge
   assign serr_event = serr_prev_reg & ~serr_sync_reg;
   assign refr_event = refr_sync_reg & ~refr_prev_reg;

   // ----------------------------------------------------------------
   // Status/control port: control bits
   // ----------------------------------------------------------------
   logic chk_dis_reg;
   logic serr_dis_reg;
   logic spk_en_reg;
   logic cnt2_en_reg;

   // Read-only positions in the write data are ignored
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         chk_dis_reg <= NSP_SC_RESET[NSP_SC_CHK_DIS];
         serr_dis_reg <= NSP_SC_RESET[NSP_SC_SERR_DIS];
         spk_en_reg <= NSP_SC_RESET[NSP_SC_SPK_EN];
         cnt2_en_reg <= NSP_SC_RESET[NSP_SC_CNT2_EN];
      end else if (wr_sc) begin
         chk_dis_reg <= i_IO_WDATA[NSP_SC_CHK_DIS];
         serr_dis_reg <= i_IO_WDATA[NSP_SC_SERR_DIS];
         spk_en_reg <= i_IO_WDATA[NSP_SC_SPK_EN];
         cnt2_en_reg <= i_IO_WDATA[NSP_SC_CNT2_EN];
      end
   end

   // ----------------------------------------------------------------
   // Status/control port: latched status
   // ----------------------------------------------------------------
   logic serr_stat_reg;
   logic chk_stat_reg;
   logic refr_tog_reg;

   // Disable bit holds status clear; a new event while enabled wins
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         serr_stat_reg <= 1'b0;
      end else if (serr_event && !serr_dis_reg) begin
         serr_stat_reg <= 1'b1;
      end else if (serr_dis_reg) begin
         serr_stat_reg <= 1'b0;
      end
   end

   // Channel check is a level; it re-latches while still asserted
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         chk_stat_reg <= 1'b0;
      end else if (!chk_sync_reg && !chk_dis_reg) begin
         chk_stat_reg <= 1'b1;
      end else if (chk_dis_reg) begin
         chk_stat_reg <= 1'b0;
      end
   end

   // Refresh toggle
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         refr_tog_reg <= 1'b0;
      end else if (refr_event) begin
         refr_tog_reg <= ~refr_tog_reg;
      end
   end

   // ----------------------------------------------------------------
   // Mask / clock index port
   // ----------------------------------------------------------------
   logic nmi_mask_reg;

   // One write updates mask and index together
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         nmi_mask_reg <= NSP_MI_MASK_RESET;
         o_RTC_INDEX <= NSP_MI_INDEX_RESET;
      end else if (wr_mi) begin
         nmi_mask_reg <= i_IO_WDATA[NSP_MI_MASK];
         o_RTC_INDEX <= i_IO_WDATA[NSP_MI_INDEX_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Fast reset / A20 port
   // ----------------------------------------------------------------
   logic a20_reg;
   logic fast_rst_reg;

   // Alternate A20 control bit
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         a20_reg <= NSP_FR_RESET[NSP_FR_A20];
      end else if (wr_fr) begin
         a20_reg <= i_IO_WDATA[NSP_FR_A20];
      end
   end

   // Fast reset control bit; the pulse engine watches its level
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         fast_rst_reg <= NSP_FR_RESET[NSP_FR_RESET_BIT];
      end else if (wr_fr) begin
         fast_rst_reg <= i_IO_WDATA[NSP_FR_RESET_BIT];
      end
   end

   // Pulse engine only re-arms after the bit is seen low
   nsp_pulse_gen #(
      .PULSE_CYCLES(PULSE_CYCLES)
   ) u_pulse (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_ctrl(fast_rst_reg),
      .o_pulse_n(o_FAST_CPU_RESET_N)
   );

   // ----------------------------------------------------------------
   // Outputs to the system
   // ----------------------------------------------------------------
   // Registered to keep outputs glitch-free; costs one clock of latency
   // NMI request: the global mask sits on top of the latched sources
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_NMI <= 1'b0;
      end else begin
         o_NMI <= ~nmi_mask_reg & (serr_stat_reg | chk_stat_reg);
      end
   end

   // Counter 2 gate
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_CNT2_GATE <= 1'b0;
      end else begin
         o_CNT2_GATE <= cnt2_en_reg;
      end
   end

   // Speaker: disabled forces 0 rather than following the counter
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_SPEAKER_OUT <= 1'b0;
      end else begin
         o_SPEAKER_OUT <= spk_en_reg & cnt2_sync_reg;
      end
   end

   // Alternate A20 follows the port bit
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_ALTERNATE_A20_GATE <= 1'b0;
      end else begin
         o_ALTERNATE_A20_GATE <= a20_reg;
      end
   end

   // ----------------------------------------------------------------
   // Read data, claim and ISA forwarding
   // ----------------------------------------------------------------
   // Status byte: latched sources, counter level and refresh toggle, then the control bits
   function automatic logic [7:0] sc_read_word(input logic serr, input logic chk,
                                               input logic cnt2, input logic refr,
                                               input logic [3:0] ctrl);
      logic [7:0] w;
      w = 8'h00;
      w[NSP_SC_SERR_STAT] = serr;
      w[NSP_SC_CHK_STAT] = chk;
      w[NSP_SC_CNT2_OUT] = cnt2;
      w[NSP_SC_REFRESH] = refr;
      w[NSP_SC_CHK_DIS:NSP_SC_CNT2_EN] = ctrl;
      return w;
   endfunction

   // Fast reset byte: fixed reserved ones in bits 5 and 2, above the two live bits
   function automatic logic [7:0] fr_read_word(input logic a20, input logic rst);
      logic [7:0] w;
      w = NSP_FR_FIXED;
      w[NSP_FR_A20] = a20;
      w[NSP_FR_RESET_BIT] = rst;
      return w;
   endfunction

   // Local answer and ISA echo strobes, one cycle after the strobe
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_IO_CLAIM <= 1'b0;
         o_ISA_FORWARD <= 1'b0;
      end else begin
         o_IO_CLAIM <= hit_sc | hit_fr;
         o_ISA_FORWARD <= hit_mi | hit_fr;
      end
   end

   // Mask port is write-only and reads come from ISA, so no data here
   // Returning to zero after one cycle keeps stale bytes off the bus
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_IO_RDATA <= 8'h00;
      end else if (hit_sc && !i_IO_WR) begin
         o_IO_RDATA <= sc_read_word(serr_stat_reg, chk_stat_reg, cnt2_sync_reg,
                                    refr_tog_reg, {chk_dis_reg, serr_dis_reg,
                                                   spk_en_reg, cnt2_en_reg});
      end else if (hit_fr && !i_IO_WR) begin
         o_IO_RDATA <= fr_read_word(a20_reg, fast_rst_reg);
      end else begin
         o_IO_RDATA <= 8'h00;
      end
   end
endmodule // nsp_ports

// ---- nsp_ports_sva.sv ----
// Purpose: Port-level checks for nsp_ports
// Assumes: Default pulse length of four clocks
// Notes: Bound to every nsp_ports instance
module nsp_ports_sva
   import nsp_pkg::*;
#(
   parameter int PULSE_CYCLES = NSP_FAST_RST_CYCLES
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic i_IO_STB,
   input wire logic i_IO_WR,
   input wire logic [15:0] i_IO_ADDR,
   input wire logic [7:0] i_IO_WDATA,
   input wire logic i_CSB_PORT92_EN,
   input wire logic o_IO_CLAIM,
   input wire logic o_ISA_FORWARD,
   input wire logic o_NMI,
   input wire logic o_CNT2_GATE,
   input wire logic o_SPEAKER_OUT,
   input wire logic o_ALTERNATE_A20_GATE,
   input wire logic o_FAST_CPU_RESET_N,
   input wire logic [6:0] o_RTC_INDEX
);
   // ---------------------------------------------
   // Decodes of the port cycle
   // ---------------------------------------------
   wire sc_wr = i_IO_STB && i_IO_WR && i_IO_ADDR == 16'h0061;
   wire mi_hit = i_IO_STB && i_IO_ADDR == 16'h0070;
   wire mi_wr = mi_hit && i_IO_WR;
   wire fr_hit = i_IO_STB && i_IO_ADDR == 16'h0092;
   wire fr_on = fr_hit && i_CSB_PORT92_EN;
   wire fr_off = fr_hit && !i_CSB_PORT92_EN;
   wire rn = o_FAST_CPU_RESET_N;

   // ---------------------------------------------
   // Checks, single clock domain
   // ---------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);

   a_fwd_mask_port: assert property (mi_hit |=> o_ISA_FORWARD)
      else $error("mask port cycle not forwarded");
   a_fr_refused: assert property (fr_off |=> !o_IO_CLAIM && !o_ISA_FORWARD)
      else $error("port 92 answered while disabled");
   a_fr_forward: assert property (fr_on |=> o_IO_CLAIM && o_ISA_FORWARD)
      else $error("port 92 cycle not passed on");
   a_pulse_len: assert property ($fell(rn) |=> !rn [*3] ##1 rn)
      else $error("fast reset pulse not four clocks");
   a_spk_off: assert property (sc_wr && !i_IO_WDATA[1] |=> ##1 !o_SPEAKER_OUT)
      else $error("speaker not held low");
   a_gate_on: assert property (sc_wr && i_IO_WDATA[0] |=> ##[0:1] o_CNT2_GATE)
      else $error("counter gate not enabled");
   a_mask_nmi: assert property (mi_wr && i_IO_WDATA[7] |=> ##1 !o_NMI)
      else $error("nmi not masked");
   a_rtc_index: assert property (mi_wr |=> o_RTC_INDEX == $past(i_IO_WDATA[6:0]))
      else $error("clock index not loaded");
   a_a20_on: assert property (fr_on && i_IO_WR && i_IO_WDATA[1] |=> ##[0:1] o_ALTERNATE_A20_GATE)
      else $error("a20 gate not driven");

   // Main scenarios reached
   c_pulse: cover property ($fell(rn));
   c_nmi: cover property ($rose(o_NMI));
   c_refused: cover property (fr_off);
endmodule // nsp_ports_sva

bind nsp_ports nsp_ports_sva #(.PULSE_CYCLES(PULSE_CYCLES)) nsp_ports_sva_inst (
   .I_CLK(I_CLK), .I_RST_B(I_RST_B), .i_IO_STB(i_IO_STB), .i_IO_WR(i_IO_WR),
   .i_IO_ADDR(i_IO_ADDR), .i_IO_WDATA(i_IO_WDATA), .i_CSB_PORT92_EN(i_CSB_PORT92_EN),
   .o_IO_CLAIM(o_IO_CLAIM), .o_ISA_FORWARD(o_ISA_FORWARD), .o_NMI(o_NMI),
   .o_CNT2_GATE(o_CNT2_GATE), .o_SPEAKER_OUT(o_SPEAKER_OUT),
   .o_ALTERNATE_A20_GATE(o_ALTERNATE_A20_GATE), .o_FAST_CPU_RESET_N(o_FAST_CPU_RESET_N),
   .o_RTC_INDEX(o_RTC_INDEX));

// ---- nsp_host_model.sv ----
// Purpose: Host issuing single-strobe I/O port cycles
// Assumes: Read data is valid the cycle after the strobe
// Notes: Drives one time unit (1ns) after each rising edge
module nsp_host_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_stb,
   output logic o_wr,
   output logic [15:0] o_addr,
   output logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus from time zero
   initial begin
      o_stb = 1'b0;
      o_wr = 1'b0;
      o_addr = 16'h0000;
      o_wdata = 8'h00;
   end

   // One cycle: strobe for one clock, answer taken at the next edge
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      @(posedge i_clk);
      #1;
      o_stb = 1'b1;
      o_wr = w;
      o_addr = a;
      o_wdata = (w && a == 16'h0061) ? (d & 8'h0F) : d;
      @(posedge i_clk);
      #1;
      o_stb = 1'b0;
      // Released bus shows the inverse so stale qualifiers cannot pass
      o_wr = ~w;
      o_addr = ~a;
      o_wdata = ~o_wdata;
      q = i_rdata;
   endtask
endmodule // nsp_host_model

// ---- nsp_ports_bench.sv ----
// Purpose: Self-checking bench for the legacy port block
// Assumes: Host model supplies the port cycles
// Notes: Event pins are driven directly by the bench
module nsp_ports_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_b, stb, wr, serr_n, iochk_n, cnt2, refr, csb;
   logic claim, fwd, nmi, gate, spk, a20, frst_n;
   logic [15:0] addr;
   logic [7:0] wdata, rdata, q;
   logic [6:0] rtc;
   int err_total, cmp_count, cyc, n;

   nsp_host_model nsp_host_model_inst (.i_clk(clk), .i_rdata(rdata), .o_stb(stb),
      .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
   nsp_ports #(.PULSE_CYCLES(4)) nsp_ports_inst (.I_CLK(clk), .I_RST_B(rst_b),
      .i_IO_STB(stb), .i_IO_WR(wr), .i_IO_ADDR(addr), .i_IO_WDATA(wdata),
      .i_SERR_N(serr_n), .i_IOCHK_N(iochk_n), .i_CNT2_OUT(cnt2), .i_REFRESH_DONE(refr),
      .i_CSB_PORT92_EN(csb), .o_IO_RDATA(rdata), .o_IO_CLAIM(claim), .o_ISA_FORWARD(fwd),
      .o_NMI(nmi), .o_CNT2_GATE(gate), .o_SPEAKER_OUT(spk), .o_ALTERNATE_A20_GATE(a20),
      .o_FAST_CPU_RESET_N(frst_n), .o_RTC_INDEX(rtc));

   // ---------------------------------------------
   // Clock, timeout and helpers
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Run needs well under a thousand clocks
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         finish_test;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      nsp_host_model_inst.io(1'b1, a, d, q);
   endtask
   task automatic rd8(input logic [15:0] a, input logic [7:0] e);
      nsp_host_model_inst.io(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // Counts low reset clocks over a window longer than one pulse
   task automatic plen(input logic [7:0] e);
      n = 0;
      repeat (10) begin
         idle(1);
         if (frst_n === 1'b0) n++;
      end
      chk(8'(n), e);
   endtask
   task automatic finish_test;
      $display("Compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_b = 0;
      serr_n = 1;
      iochk_n = 1;
      cnt2 = 0;
      refr = 0;
      csb = 1;
      repeat (4) @(posedge clk);
      #1 rst_b = 1;
      rd8(16'h0061, 8'h00);
      rd8(16'h0092, 8'h24);
      rd8(16'h0070, 8'h00);
      chk(fwd, 8'h01);
      chk(claim, 8'h00);
      // Two refresh cycles toggle bit 4 and back
      for (int i = 0; i < 2; i++) begin
         refr = 1;
         idle(2);
         refr = 0;
         idle(4);
         rd8(16'h0061, i ? 8'h00 : 8'h10);
      end
      // Counter treated as programmed before bit 5 is trusted
      cnt2 = 1;
      idle(4);
      rd8(16'h0061, 8'h20);
      chk(claim, 8'h01);
      wr8(16'h0061, 8'h23);
      idle(3);
      chk(spk, 8'h01);
      chk(gate, 8'h01);
      wr8(16'h0061, 8'h01);
      idle(3);
      chk(spk, 8'h00);
      cnt2 = 0;
      wr8(16'h0061, 8'h00);
      idle(4);
      chk(gate, 8'h00);
      // System error, mask and clear sequence
      wr8(16'h0070, 8'h05);
      chk(rtc, 8'h05);
      serr_n = 0;
      idle(1);
      serr_n = 1;
      idle(5);
      rd8(16'h0061, 8'h80);
      chk(nmi, 8'h01);
      wr8(16'h0070, 8'h80);
      idle(2);
      chk(nmi, 8'h00);
      chk(rtc, 8'h00);
      wr8(16'h0070, 8'h00);
      idle(2);
      chk(nmi, 8'h01);
      wr8(16'h0061, 8'h04);
      wr8(16'h0061, 8'h00);
      idle(3);
      rd8(16'h0061, 8'h00);
      chk(nmi, 8'h00);
      // Channel check held low, then cleared while still low
      iochk_n = 0;
      idle(5);
      rd8(16'h0061, 8'h40);
      chk(nmi, 8'h01);
      wr8(16'h0061, 8'h08);
      idle(2);
      rd8(16'h0061, 8'h08);
      chk(nmi, 8'h00);
      iochk_n = 1;
      idle(4);
      wr8(16'h0061, 8'h00);
      // Fast reset port, refused then enabled
      csb = 0;
      wr8(16'h0092, 8'h03);
      chk(claim, 8'h00);
      chk(fwd, 8'h00);
      idle(6);
      chk(a20, 8'h00);
      chk(frst_n, 8'h01);
      csb = 1;
      wr8(16'h0092, 8'h02);
      idle(2);
      chk(a20, 8'h01);
      rd8(16'h0092, 8'h26);
      chk(fwd, 8'h01);
      chk(claim, 8'h01);
      wr8(16'h0092, 8'h03);
      plen(8'h04);
      wr8(16'h0092, 8'h03);
      plen(8'h00);
      wr8(16'h0092, 8'h02);
      wr8(16'h0092, 8'h03);
      plen(8'h04);
      rd8(16'h0092, 8'h27);
      // Second reset in mid-run
      rst_b = 0;
      idle(2);
      rst_b = 1;
      rd8(16'h0092, 8'h24);
      chk(a20, 8'h00);
      chk(frst_n, 8'h01);
      finish_test;
   end
endmodule // nsp_ports_bench
